// [esm_consts.svh]
/*
 * Constants for the enabling switch monitor: register offsets, field
 * positions, reset values, diagnostic codes and timing figures.
 * Assumes the includer runs on the 20 MHz scan clock.
 */
`ifndef ESM_CONSTS_SVH
`define ESM_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define ESM_OFS_CTRL     8'h00
`define ESM_OFS_STATUS   8'h04
`define ESM_OFS_TIME     8'h08
`define ESM_OFS_DIAG     8'h0c

// Control register fields
`define ESM_CTRL_NOGATE_BIT  0
`define ESM_CTRL_LIMIT_LSB   8
`define ESM_CTRL_LIMIT_MSB   12

// Reset values: no external gate needed, time limit off
`define ESM_RST_NOGATE   1'b1
`define ESM_RST_LIMIT    5'h00
`define ESM_LIMIT_MAX    5'h14

// Diagnostic word codes
`define ESM_DG_NONE      16'h0000
`define ESM_DG_WAIT      16'h2001
`define ESM_DG_ONE_OPEN  16'h2005
`define ESM_DG_OFF_POS   16'h2012
`define ESM_DG_ON_POS    16'h8002
`define ESM_DG_TIMEOUT   16'hf002
`define ESM_DG_MISMATCH  16'hf00e
`define ESM_DG_UNDEF     16'hf00f

// Timing: clock rate, time units and their cycle counts
`define ESM_CLK_HZ       20000000
`define ESM_TICK_MS      1000
`define ESM_DISC_MS      100
`define ESM_SETTLE_MS    500
`define ESM_STEP_S       30
`define ESM_CYC_PER_MS   (`ESM_CLK_HZ / 1000)

`endif

// [esm_pkg.sv]
/*
 * Types of the enabling switch monitor.
 * Assumes esm_consts.svh carries every numeric constant.
 */
package esm_pkg;

	// Monitor states, binary codes written out
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_WAIT0   = 3'b001,
		ST_READY   = 3'b010,
		ST_ON      = 3'b011,
		ST_WITHDRN = 3'b100,
		ST_PARTIAL = 3'b101,
		ST_FAULT   = 3'b110
	} esm_state_type;

endpackage

// [esm_enable_switch.sv]
/*
 * Enabling switch monitor: decodes a three-position, two-contact switch,
 * drives release and fault contacts, limits bridging time, reports the
 * elapsed time and a diagnostic word, and exposes control over Wishbone.
 * Assumes channel, arming and gate inputs are synchronous to clk_i.
 */
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "esm_consts.svh"

// Behaviour
// RL1: Option bit selects whether the external gate is needed; default not.
// RL2: Limit is off or 0.5 to 10 minutes in half-minute steps; default off.
// RL3: With limit on, holding position 1 past it opens release, sets fault.
// RL4: Elapsed bridging time is always presented on an output.
// RL5: Diagnostic word: 2001 waiting, 2005 one channel open, 2012 switch off.
// RL6: Diagnostic word is 0000 when unarmed, 8002 when on and released.
// RL7: Diagnostic word: F002 time exceeded, F00F undefined position.
// RL8: Diagnostic word is 61454 when one channel opened and closed alone.
// RL9: Release may start only after arming while the switch is at position 0.
// RL10: Armed at position 0, moving to position 1 closes the release contact.
// RL11: Position 2 (panic) withdraws release at once.
// RL12: After withdrawal, release stays open on the way back through 1.
// RL13: Letting go from position 1 back to 0 withdraws release.
// RL14: Fault contact closes while a fault stands, opens once acknowledged.
// RL15: Wire break or channel disagreement is a fault, cleared at position 0.
// RL16: A time-out fault is cleared by returning to 0, allowing a new cycle.
// RL17: Inputs are two channels, an arming input and an optional gate input.
// RL18: With limit off, release holds as long as both channels are asserted.
// RL19: Both high is position 1, both low 0 or 2; lasting split undefined.
// RL20: The bridging timer counts only while released, clears on return to 0.
module esm_enable_switch
	import esm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES   = `ESM_TICK_MS * `ESM_CYC_PER_MS,
	parameter int unsigned DISC_CYCLES   = `ESM_DISC_MS * `ESM_CYC_PER_MS,
	parameter int unsigned SETTLE_CYCLES = `ESM_SETTLE_MS * `ESM_CYC_PER_MS
) (
	input  wire logic        clk_i,             // Scan clock, 20 MHz
	input  wire logic        rst_i,             // Synchronous reset, high
	input  wire logic        wb_cyc_i,          // Wishbone cycle
	input  wire logic        wb_stb_i,          // Wishbone strobe
	input  wire logic        wb_we_i,           // Wishbone write
	input  wire logic [7:0]  wb_adr_i,          // Byte address
	input  wire logic [3:0]  wb_sel_i,          // Byte lanes
	input  wire logic [31:0] wb_dat_i,          // Write data
	output logic      [31:0] wb_dat_o,          // Read data
	output logic             wb_ack_o,          // Acknowledge
	input  wire logic        arming_coil_i,     // Arming from other logic
	input  wire logic        channel_one_input_i, // Switch contact A
	input  wire logic        channel_two_input_i, // Switch contact B
	input  wire logic        gate_enable_i,     // Optional block gate
	output logic             release_contact_o, // Release closed when high
	output logic             fault_contact_o,   // Fault closed when high
	output logic      [15:0] actual_time_output_o, // Elapsed seconds
	output logic      [15:0] diagnostic_word_o  // Status or error code
);

	esm_state_type state_r;
	esm_state_type state_nxt;
	logic          no_external_gate_r;
	logic [4:0]    bridging_time_limit_r;
	logic [15:0]   fault_code_r;
	logic [15:0]   fault_code_nxt;
	logic [31:0]   tick_cnt_r;
	logic [31:0]   disc_cnt_r;
	logic [31:0]   settle_cnt_r;
	logic [15:0]   time_r;
	logic          ack_r;
	logic [31:0]   dat_r;
	logic          both_hi;
	logic          both_lo;
	logic          active;
	logic          disc_done;
	logic          settle_done;
	logic          limit_hit;
	logic          bus_req;
	logic [15:0]   limit_s;

	// RL17 RL19 position decode
	assign both_hi = channel_one_input_i & channel_two_input_i;
	assign both_lo = ~channel_one_input_i & ~channel_two_input_i;

	// RL1 gate requirement
	// Block runs when armed and either the gate is ignored or present
	assign active = arming_coil_i & (no_external_gate_r | gate_enable_i);

	// Limit in seconds; zero means no limit is enforced
	assign limit_s = 16'(bridging_time_limit_r) * 16'(`ESM_STEP_S);

	// RL3 bridging limit reached
	assign limit_hit = (bridging_time_limit_r != 5'h00) && (time_r >= limit_s);

	assign disc_done   = (disc_cnt_r >= DISC_CYCLES - 1);
	assign settle_done = (settle_cnt_r >= SETTLE_CYCLES - 1);
	assign bus_req     = wb_cyc_i & wb_stb_i;

	// Next state of the switch monitor
	always_comb begin
		state_nxt      = state_r;
		fault_code_nxt = fault_code_r;
		case (state_r)
			ST_IDLE: begin
				// RL9 arm only from position 0
				if (active && both_lo)
					state_nxt = ST_READY;
				else if (active)
					state_nxt = ST_WAIT0;
			end
			ST_WAIT0: begin
				if (!active)
					state_nxt = ST_IDLE;
				else if (both_lo)
					state_nxt = ST_READY;
			end
			ST_READY: begin
				// RL10 press to position 1
				if (!active)
					state_nxt = ST_IDLE;
				else if (both_hi)
					state_nxt = ST_ON;
				else if (!both_lo)
					state_nxt = ST_PARTIAL;
			end
			ST_PARTIAL: begin
				// RL8 one channel opened and closed alone
				if (!active)
					state_nxt = ST_IDLE;
				else if (both_hi)
					state_nxt = ST_ON;
				else if (both_lo) begin
					state_nxt      = ST_FAULT;
					fault_code_nxt = `ESM_DG_MISMATCH;
				end else if (disc_done) begin
					// RL15 sustained disagreement is a wire fault
					state_nxt      = ST_FAULT;
					fault_code_nxt = `ESM_DG_UNDEF;
				end
			end
			ST_ON: begin
				// RL3 time-out fault
				if (limit_hit) begin
					state_nxt      = ST_FAULT;
					fault_code_nxt = `ESM_DG_TIMEOUT;
				end else if (!active || !both_hi)
					// RL11 RL13 RL18 drop as soon as a channel opens
					state_nxt = ST_WITHDRN;
			end
			ST_WITHDRN: begin
				// RL12 stay open until position 0 has settled
				if (!both_lo && !both_hi && disc_done) begin
					state_nxt      = ST_FAULT;
					fault_code_nxt = `ESM_DG_UNDEF;
				end else if (both_lo && settle_done)
					state_nxt = active ? ST_READY : ST_IDLE;
			end
			ST_FAULT: begin
				// RL15 RL16 acknowledge by position 0
				if (both_lo) begin
					state_nxt      = active ? ST_READY : ST_IDLE;
					fault_code_nxt = `ESM_DG_NONE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// State and fault code registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r      <= ST_IDLE;
			fault_code_r <= `ESM_DG_NONE;
		end else begin
			state_r      <= state_nxt;
			fault_code_r <= fault_code_nxt;
		end
	end

	// Discrepancy window while the channels disagree
	always_ff @(posedge clk_i) begin
		if (rst_i || both_hi || both_lo)
			disc_cnt_r <= 32'h0000_0000;
		else if (!disc_done)
			disc_cnt_r <= disc_cnt_r + 32'h0000_0001;
	end

	// Settle window: a long position 0 ends a withdrawal, which
	// tells a true release apart from a pass through position 1
	always_ff @(posedge clk_i) begin
		if (rst_i || !both_lo || state_r != ST_WITHDRN)
			settle_cnt_r <= 32'h0000_0000;
		else if (!settle_done)
			settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
	end

	// RL20 one-second tick and elapsed bridging time
	always_ff @(posedge clk_i) begin
		if (rst_i || state_nxt == ST_READY || state_nxt == ST_IDLE) begin
			tick_cnt_r <= 32'h0000_0000;
			time_r     <= 16'h0000;
		end else if (state_r == ST_ON) begin
			if (tick_cnt_r >= TICK_CYCLES - 1) begin
				tick_cnt_r <= 32'h0000_0000;
				time_r     <= time_r + 16'h0001;
			end else
				tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	// RL14 contacts from the next state, so both leave flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			release_contact_o <= 1'b0;
			fault_contact_o   <= 1'b0;
		end else begin
			release_contact_o <= (state_nxt == ST_ON);
			fault_contact_o   <= (state_nxt == ST_FAULT);
		end
	end

	// RL4 elapsed time output
	always_ff @(posedge clk_i) begin
		if (rst_i)
			actual_time_output_o <= 16'h0000;
		else
			actual_time_output_o <= time_r;
	end

	// RL5 RL6 RL7 diagnostic word follows the next state
	always_ff @(posedge clk_i) begin
		if (rst_i)
			diagnostic_word_o <= `ESM_DG_NONE;
		else begin
			case (state_nxt)
				ST_WAIT0:   diagnostic_word_o <= `ESM_DG_WAIT;
				ST_READY:   diagnostic_word_o <= `ESM_DG_OFF_POS;
				ST_PARTIAL: diagnostic_word_o <= `ESM_DG_ONE_OPEN;
				ST_ON:      diagnostic_word_o <= `ESM_DG_ON_POS;
				ST_WITHDRN: diagnostic_word_o <= `ESM_DG_OFF_POS;
				ST_FAULT:   diagnostic_word_o <= fault_code_nxt;
				default:    diagnostic_word_o <= `ESM_DG_NONE;
			endcase
		end
	end

	// Wishbone acknowledge: one cycle after the request, one cycle long
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req & ~ack_r;
	end

	// RL1 RL2 control writes land on the edge where ack is sampled
	// Limit values above ten minutes are clamped, never wrapped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			no_external_gate_r    <= `ESM_RST_NOGATE;
			bridging_time_limit_r <= `ESM_RST_LIMIT;
		end else if (bus_req && ack_r && wb_we_i &&
				wb_adr_i == `ESM_OFS_CTRL) begin
			if (wb_sel_i[0])
				no_external_gate_r <= wb_dat_i[`ESM_CTRL_NOGATE_BIT];
			if (wb_sel_i[1]) begin
				if (wb_dat_i[`ESM_CTRL_LIMIT_MSB:`ESM_CTRL_LIMIT_LSB] >
						`ESM_LIMIT_MAX)
					bridging_time_limit_r <= `ESM_LIMIT_MAX;
				else
					bridging_time_limit_r <=
						wb_dat_i[`ESM_CTRL_LIMIT_MSB:`ESM_CTRL_LIMIT_LSB];
			end
		end
	end

	// Read data captured with the acknowledge; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_r <= 32'h0000_0000;
		else if (bus_req && !ack_r) begin
			if (wb_adr_i == `ESM_OFS_CTRL)
				dat_r <= {19'h0, bridging_time_limit_r, 7'h0,
					no_external_gate_r};
			else if (wb_adr_i == `ESM_OFS_STATUS)
				dat_r <= {24'h0, 1'b0, state_r, 1'b0, active,
					fault_contact_o, release_contact_o};
			else if (wb_adr_i == `ESM_OFS_TIME)
				dat_r <= {16'h0, time_r};
			else if (wb_adr_i == `ESM_OFS_DIAG)
				dat_r <= {16'h0, diagnostic_word_o};
			else
				dat_r <= 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// Checks on the monitor, all in the scan clock domain
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_release_both_hi: assert property ( // RL18
		release_contact_o |-> $past(both_hi))
		else $error("Release closed without both channels high");

	a_panic_withdraw: assert property ( // RL11
		(state_r == ST_ON && both_lo && !limit_hit) |=>
			!release_contact_o ##1 !release_contact_o)
		else $error("Release not withdrawn on panic or let-go");

	a_pass_through_one: assert property ( // RL12
		(state_r == ST_WITHDRN && both_hi) |=> !release_contact_o)
		else $error("Release reclosed while passing position 1");

	a_timeout_fault: assert property ( // RL3
		(state_r == ST_ON && limit_hit) |=>
			(fault_contact_o && !release_contact_o &&
			 diagnostic_word_o == 16'hf002))
		else $error("Bridging time-out not reported");

	a_fault_ack: assert property ( // RL14
		(state_r == ST_FAULT && both_lo) |=>
			(!fault_contact_o && diagnostic_word_o != 16'hf002))
		else $error("Fault not cleared by position 0");

	a_one_chan_code: assert property ( // RL8
		(state_r == ST_PARTIAL && both_lo && active) |=>
			(diagnostic_word_o == 16'd61454 && fault_contact_o))
		else $error("Single channel mismatch code missing");

	a_unarmed_zero: assert property ( // RL6
		(state_r == ST_IDLE && !active) |=> diagnostic_word_o == 16'h0000)
		else $error("Diagnostic word not zero when unarmed");

	a_arm_needs_zero: assert property ( // RL9
		(state_r == ST_IDLE && active && !both_lo) |=>
			(diagnostic_word_o == 16'h2001 && !release_contact_o))
		else $error("Armed away from position 0 without waiting");

	a_timer_frozen: assert property ( // RL20
		(state_r != ST_ON && state_nxt != ST_READY &&
		 state_nxt != ST_IDLE) |=> $stable(time_r))
		else $error("Bridging timer ran while not released");

	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle");

	c_release_on: cover property (
		state_r == ST_READY ##1 state_r == ST_ON);
	c_timeout: cover property (
		state_r == ST_ON ##1 state_r == ST_FAULT);
	c_withdraw_back: cover property (
		state_r == ST_WITHDRN ##1 state_r == ST_READY);
	c_undefined: cover property (
		diagnostic_word_o == 16'hf00f);

endmodule // esm_enable_switch

// [esm_switch_model.sv]
/*
 * Two-contact, three-position enabling switch seen from the monitor.
 * Assumes the bench commands a position on pos_i right after a clock edge.
 */
`timescale 1ns/1ps
module esm_switch_model (
	input  wire logic       clk_i,   // Scan clock
	input  wire logic [1:0] pos_i,   // 0 rest, 1 pressed, 2/3 one contact
	output logic            ch_a_o,  // Contact A, high when actuated
	output logic            ch_b_o   // Contact B, high when actuated
);
	// two contacts
	// Contacts follow the command one scan later, like a real bounce-free make
	always_ff @(posedge clk_i) begin
		ch_a_o <= (pos_i == 2'd1) || (pos_i == 2'd2);
		ch_b_o <= (pos_i == 2'd1) || (pos_i == 2'd3);
	end
endmodule // esm_switch_model

// [esm_enable_switch_tb_top.sv]
/*
 * Self-checking bench of the enabling switch monitor.
 * Assumes short tick, discrepancy and settle counts set at the instance.
 */
`timescale 1ns/1ps
`include "esm_consts.svh"
module esm_enable_switch_tb_top;
	logic        clk, rst, cyc, stb, we, arm, gate, ch1, ch2, rel, flt, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, rd;
	logic [15:0] tim, diag;
	logic [1:0]  pos;
	int          n_fail, checks_done;

	// Ten-cycle seconds keep a 30 s limit at 300 cycles
	// Discrepancy window long enough for a bench round trip to position 0
	esm_enable_switch #(.TICK_CYCLES(10), .DISC_CYCLES(8),
		.SETTLE_CYCLES(6)) dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack), .arming_coil_i(arm),
		.channel_one_input_i(ch1), .channel_two_input_i(ch2),
		.gate_enable_i(gate), .release_contact_o(rel),
		.fault_contact_o(flt), .actual_time_output_o(tim),
		.diagnostic_word_o(diag));
	esm_switch_model sw (.clk_i(clk), .pos_i(pos), .ch_a_o(ch1),
		.ch_b_o(ch2));

	always #25 clk = ~clk;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One classic cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
		sel <= 4'h3;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		if (i == 50) check("ack", 32'h0, 32'h1);
		rd = dat_r;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic go(input logic [1:0] p, input int n);
		@(posedge clk);
		pos <= p;
		repeat (n) @(posedge clk);
	endtask

	// Bounded wait for a diagnostic code, judged once
	task automatic wait_diag(input logic [15:0] code);
		int i;
		for (i = 0; i < 600 && diag !== code; i++) @(posedge clk);
		check("diag", {16'h0, diag}, {16'h0, code});
	endtask

	task automatic t_regs();
		wb(1'b0, `ESM_OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h1);
		wb(1'b0, 8'h10, 32'h0);
		check("unmapped", rd, 32'h0);
		wb(1'b1, `ESM_OFS_CTRL, 32'h1f01);
		wb(1'b0, `ESM_OFS_CTRL, 32'h0);
		check("limit clamp", rd, 32'h1401);
		check("diag unarmed", {16'h0, diag}, 32'h0);
		wb(1'b1, `ESM_OFS_CTRL, 32'h1);
		$display("test regs done");
	endtask

	task automatic t_cycle();
		@(posedge clk);
		arm <= 1'b1;
		wait_diag(`ESM_DG_OFF_POS);
		go(2'd1, 4);
		check("release on", rel, 1'b1);
		wait_diag(`ESM_DG_ON_POS);
		repeat (100) @(posedge clk);
		check("release held", rel, 1'b1);
		check("time runs", tim, 32'd10);
		wb(1'b0, `ESM_OFS_DIAG, 32'h0);
		check("diag reg", rd, {16'h0, `ESM_DG_ON_POS});
		wb(1'b0, `ESM_OFS_STATUS, 32'h0);
		check("status on", rd, 32'h35);
		go(2'd0, 4);
		check("let go", rel, 1'b0);
		go(2'd1, 4);
		check("quick repress", rel, 1'b0);
		go(2'd0, 20);
		check("time cleared", tim, 16'h0);
		$display("test cycle done");
	endtask

	task automatic t_faults();
		go(2'd2, 3);
		wait_diag(`ESM_DG_ONE_OPEN);
		go(2'd0, 0);
		wait_diag(16'd61454);
		go(2'd0, 20);
		go(2'd3, 0);
		wait_diag(`ESM_DG_UNDEF);
		check("fault on", flt, 1'b1);
		go(2'd0, 20);
		check("fault ack", flt, 1'b0);
		$display("test faults done");
	endtask

	task automatic t_limit();
		wb(1'b1, `ESM_OFS_CTRL, 32'h0101);
		go(2'd1, 4);
		check("limit rel", rel, 1'b1);
		repeat (290) @(posedge clk);
		check("before limit", rel, 1'b1);
		wait_diag(`ESM_DG_TIMEOUT);
		@(posedge clk);
		check("timeout rel", rel, 1'b0);
		check("timeout flt", flt, 1'b1);
		go(2'd0, 20);
		check("timeout ack", flt, 1'b0);
		go(2'd1, 4);
		check("new cycle", rel, 1'b1);
		go(2'd0, 20);
		$display("test limit done");
	endtask

	task automatic t_gate();
		wb(1'b1, `ESM_OFS_CTRL, 32'h0);
		@(posedge clk);
		arm <= 1'b0;
		wait_diag(`ESM_DG_NONE);
		go(2'd1, 3);
		@(posedge clk);
		arm <= 1'b1;
		repeat (3) @(posedge clk);
		check("gated diag", {16'h0, diag}, 32'h0);
		check("gated", rel, 1'b0);
		@(posedge clk);
		gate <= 1'b1;
		wait_diag(`ESM_DG_WAIT);
		check("not at rest", rel, 1'b0);
		go(2'd0, 20);
		go(2'd1, 4);
		check("gate rel", rel, 1'b1);
		$display("test gate done");
	endtask

	initial begin
		clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
		adr = 8'h00; sel = 4'h0; dat_w = 32'h0; arm = 1'b0;
		gate = 1'b0; pos = 2'd0; n_fail = 0; checks_done = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_cycle();
		t_faults();
		t_limit();
		t_gate();
		end_of_test();
	end

	// Watchdog well beyond the several hundred cycles the tests need
	initial begin
		#2000000;
		n_fail++;
		end_of_test();
	end
endmodule // esm_enable_switch_tb_top
